// ===== hdl/pbc_defines.vh
// Constants for the basic control register block of the PHY management space.
// Assumes inclusion by bare name from hdl/ and a 10 MHz management-side clock.
// Behaviour
// - The block answers only entry 0h of the 32-entry management register space; standard entries 1h-Fh and vendor entries 10h-1Fh go unanswered.
// - Writing one to bit 15 starts a software reset and the bit clears itself so it reads zero.
// - Bit 13 picks the manual speed, one for 100 Mbps and zero for 10 Mbps, and is ignored while auto-negotiation is on.
// - Bit 12 enables auto-negotiation, and when it is on the negotiated speed and duplex win over bits 13 and 8.
// - Reset loads the negotiation-enable, isolate and inverted duplex bits from their straps, speed from a strap on one variant, and clears the rest.
// - In power-down the first reset write only clears power-down and the second resets and re-latches the straps.
// - Bit 10 isolates the device from its MAC data interface and zero restores normal operation.
`ifndef PBC_DEFINES_VH
`define PBC_DEFINES_VH
`define PBC_NUM_REGS        6'd32
`define PBC_VENDOR_BASE     5'h10
`define PBC_REG_CONTROL     5'h00
`define PBC_BIT_RESET       15
`define PBC_BIT_LOOPBACK    14
`define PBC_BIT_SPEED       13
`define PBC_BIT_ANEG        12
`define PBC_BIT_PDOWN       11
`define PBC_BIT_ISOLATE     10
`define PBC_BIT_ANRESTART   9
`define PBC_BIT_DUPLEX      8
`define PBC_BIT_COLTEST     7
`define PBC_RESERVED_RESET  7'h00
`define PBC_SOFT_RESET_CYC  4'hF
`endif

// ===== hdl/pbc_control.v
// Basic control register with a Clause 22 management slave on a sampled clock pin.
// Assumes mdc and mdio come from outside, straps are static pins, and the
// negotiated speed and duplex come from same-clock negotiation logic.
`timescale 1ns/1ps
`include "pbc_defines.vh"
module pbc_control (
    input  wire        mclk_i,
    input  wire        resetn_i,
    input  wire        mdc_i,
    input  wire        mdio_i,
    input  wire [4:0]  phy_addr_i,
    input  wire        autoneg_enable_strap_i,
    input  wire        isolate_strap_i,
    input  wire        speed_strap_i,
    input  wire        speed_strap_present_i,
    input  wire        duplex_strap_i,
    input  wire        aneg_speed_i,
    input  wire        aneg_duplex_i,
    output reg         mdio_o,
    output reg         mdio_oe_o,
    output reg         soft_reset_o,
    output reg         power_down_o,
    output reg         isolate_o,
    output reg         loopback_o,
    output reg         speed_100_o,
    output reg         full_duplex_o,
    output reg         aneg_enable_o,
    output reg         aneg_restart_o,
    output reg         col_test_o
);
    localparam ST_IDLE = 2'd0;
    localparam ST_HEAD = 2'd1;
    localparam ST_TA   = 2'd2;
    localparam ST_DATA = 2'd3;

    // Three-stage samplers for the pins; the first stage feeds only the second.
    reg [2:0]  mdc_s_q;
    reg [2:0]  mdio_s_q;
    reg        mdc_f_q;
    reg        mdio_f_q;
    reg [1:0]  state_q;
    reg [5:0]  cnt_q;
    reg [13:0] head_q;
    reg [15:0] sh_q;
    reg        rd_q;
    reg        hit_q;
    reg [15:0] wdat_q;
    reg        wr_q;
    reg        ctl_loop_q;
    reg        ctl_speed_q;
    reg        ctl_aneg_q;
    reg        ctl_pdown_q;
    reg        ctl_iso_q;
    reg        ctl_dup_q;
    reg        ctl_col_q;
    reg [3:0]  rst_cnt_q;
    reg        relatch_q;
    wire       rise;
    wire       fall;
    wire [15:0] ctl_word;

    // A level counts only once the second and third stages agree.
    always @(posedge mclk_i) begin
        mdc_s_q  <= {mdc_s_q[1:0], mdc_i};
        mdio_s_q <= {mdio_s_q[1:0], mdio_i};
        if (!resetn_i) begin
            mdc_f_q  <= 1'b0;
            mdio_f_q <= 1'b1;
        end else begin
            if (mdc_s_q[1] == mdc_s_q[2])
                mdc_f_q <= mdc_s_q[2];
            if (mdio_s_q[1] == mdio_s_q[2])
                mdio_f_q <= mdio_s_q[2];
        end
    end

    assign rise = (mdc_s_q[1] == mdc_s_q[2]) && mdc_s_q[2] && !mdc_f_q;
    assign fall = (mdc_s_q[1] == mdc_s_q[2]) && !mdc_s_q[2] && mdc_f_q;

    // Self-clearing bits read as zero; reserved bits read as their reset value.
    assign ctl_word = {1'b0, ctl_loop_q, ctl_speed_q, ctl_aneg_q, ctl_pdown_q,
                       ctl_iso_q, 1'b0, ctl_dup_q, ctl_col_q, `PBC_RESERVED_RESET};

    // Frame engine: preamble skip, start/op/phy/reg header, turnaround, data.
    always @(posedge mclk_i) begin
        if (!resetn_i) begin
            state_q   <= ST_IDLE;
            cnt_q     <= 6'd0;
            head_q    <= 14'h0000;
            sh_q      <= 16'h0000;
            rd_q      <= 1'b0;
            hit_q     <= 1'b0;
            wdat_q    <= 16'h0000;
            wr_q      <= 1'b0;
            mdio_o    <= 1'b0;
            mdio_oe_o <= 1'b0;
        end else begin
            wr_q <= 1'b0;
            case (state_q)
                ST_IDLE: begin
                    mdio_oe_o <= 1'b0;
                    if (rise && !mdio_f_q) begin // Start bit 0 after preamble ones.
                        state_q <= ST_HEAD;
                        cnt_q   <= 6'd1;
                        head_q  <= 14'h0000;
                    end
                end
                ST_HEAD: begin
                    if (rise) begin
                        head_q <= {head_q[12:0], mdio_f_q};
                        cnt_q  <= cnt_q + 6'd1;
                        if (cnt_q == 6'd13) begin
                            // Twelve bits are held: st1 at 11, op at 10:9, phy at 8:4 and
                            // the upper reg bits at 3:0; the reg LSB is on the pin now.
                            rd_q  <= (head_q[10:9] == 2'b10);
                            // Only index 0 decodes; every other index leaves hit_q low.
                            hit_q <= (head_q[8:4] == phy_addr_i) &&
                                     ({head_q[3:0], mdio_f_q} == `PBC_REG_CONTROL);
                            if (head_q[11] != 1'b1 || head_q[10:9] == 2'b00 ||
                                head_q[10:9] == 2'b11)
                                state_q <= ST_IDLE;
                            else
                                state_q <= ST_TA;
                            cnt_q <= 6'd0;
                            sh_q  <= ctl_word;
                        end
                    end
                end
                ST_TA: begin
                    if (rise)
                        cnt_q <= cnt_q + 6'd1;
                    // Device drives zero in the second turnaround bit of a read.
                    if (fall && cnt_q == 6'd1 && rd_q && hit_q) begin
                        mdio_oe_o <= 1'b1;
                        mdio_o    <= 1'b0;
                    end
                    if (rise && cnt_q == 6'd1) begin
                        state_q <= ST_DATA;
                        cnt_q   <= 6'd0;
                    end
                end
                ST_DATA: begin
                    if (fall && rd_q && hit_q) begin
                        mdio_o <= sh_q[15];
                        sh_q   <= {sh_q[14:0], 1'b0};
                    end
                    if (rise) begin
                        wdat_q <= {wdat_q[14:0], mdio_f_q};
                        cnt_q  <= cnt_q + 6'd1;
                        if (cnt_q == 6'd15) begin
                            state_q <= ST_IDLE;
                            wr_q    <= !rd_q && hit_q;
                        end
                    end
                    if (fall && cnt_q == 6'd16)
                        mdio_oe_o <= 1'b0;
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // Control bits, strap loading and the power-down reset sequence.
    always @(posedge mclk_i) begin
        if (!resetn_i) begin
            ctl_loop_q  <= 1'b0;
            ctl_speed_q <= 1'b0;
            ctl_aneg_q  <= 1'b0;
            ctl_pdown_q <= 1'b0;
            ctl_iso_q   <= 1'b0;
            ctl_dup_q   <= 1'b0;
            ctl_col_q   <= 1'b0;
            rst_cnt_q   <= 4'h0;
            relatch_q   <= 1'b1;
            aneg_restart_o <= 1'b0;
        end else begin
            aneg_restart_o <= 1'b0;
            if (relatch_q) begin
                // Straps are caught by a clocked step after reset release.
                relatch_q   <= 1'b0;
                ctl_aneg_q  <= autoneg_enable_strap_i;
                ctl_iso_q   <= isolate_strap_i;
                ctl_speed_q <= speed_strap_present_i & speed_strap_i;
                ctl_dup_q   <= ~duplex_strap_i;
                ctl_loop_q  <= 1'b0;
                ctl_pdown_q <= 1'b0;
                ctl_col_q   <= 1'b0;
            end else if (rst_cnt_q != 4'h0) begin
                rst_cnt_q <= rst_cnt_q - 4'h1;
                if (rst_cnt_q == 4'h1)
                    relatch_q <= 1'b1;
            end else if (wr_q) begin
                if (wdat_q[`PBC_BIT_RESET] && ctl_pdown_q) begin
                    ctl_pdown_q <= 1'b0;
                end else if (wdat_q[`PBC_BIT_RESET]) begin
                    rst_cnt_q <= `PBC_SOFT_RESET_CYC;
                end else begin
                    ctl_loop_q  <= wdat_q[`PBC_BIT_LOOPBACK];
                    ctl_speed_q <= wdat_q[`PBC_BIT_SPEED];
                    ctl_aneg_q  <= wdat_q[`PBC_BIT_ANEG];
                    ctl_pdown_q <= wdat_q[`PBC_BIT_PDOWN];
                    ctl_iso_q   <= wdat_q[`PBC_BIT_ISOLATE];
                    ctl_dup_q   <= wdat_q[`PBC_BIT_DUPLEX];
                    ctl_col_q   <= wdat_q[`PBC_BIT_COLTEST];
                    aneg_restart_o <= wdat_q[`PBC_BIT_ANRESTART];
                end
            end
        end
    end

    // Registered steering outputs; negotiation overrides manual speed and duplex.
    always @(posedge mclk_i) begin
        if (!resetn_i) begin
            soft_reset_o  <= 1'b0;
            power_down_o  <= 1'b0;
            isolate_o     <= 1'b0;
            loopback_o    <= 1'b0;
            speed_100_o   <= 1'b0;
            full_duplex_o <= 1'b0;
            aneg_enable_o <= 1'b0;
            col_test_o    <= 1'b0;
        end else begin
            soft_reset_o  <= (rst_cnt_q != 4'h0);
            power_down_o  <= ctl_pdown_q;
            isolate_o     <= ctl_iso_q;
            loopback_o    <= ctl_loop_q;
            speed_100_o   <= ctl_aneg_q ? aneg_speed_i : ctl_speed_q;
            full_duplex_o <= ctl_aneg_q ? aneg_duplex_i : ctl_dup_q;
            aneg_enable_o <= ctl_aneg_q;
            col_test_o    <= ctl_col_q;
        end
    end
endmodule // pbc_control

// ===== dv/pbc_control_asserts.sv
// Checker for the basic control block; it watches the block's ports only.
// Assumes one clock domain with a synchronous active-low reset.
`timescale 1ns/1ps
module pbc_control_asserts (
    input logic mclk_i,
    input logic resetn_i,
    input logic autoneg_enable_strap_i,
    input logic isolate_strap_i,
    input logic aneg_speed_i,
    input logic aneg_duplex_i,
    input logic mdio_o,
    input logic mdio_oe_o,
    input logic soft_reset_o,
    input logic power_down_o,
    input logic isolate_o,
    input logic loopback_o,
    input logic speed_100_o,
    input logic full_duplex_o,
    input logic aneg_enable_o,
    input logic aneg_restart_o
);
    logic [4:0] hi_cnt_q;
    // Counts how many cycles the software reset pulse has stood high.
    always @(posedge mclk_i) hi_cnt_q <= (resetn_i && soft_reset_o) ? hi_cnt_q + 5'h01 : 5'h00;
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!resetn_i);
    rel_zero_a: assert property (
        $rose(resetn_i) |-> !isolate_o && !aneg_enable_o && !soft_reset_o)
        else $error("outputs not clear at reset release");
    strap_load_a: assert property (
        $rose(resetn_i) |-> ##[1:3] (aneg_enable_o == autoneg_enable_strap_i
        && isolate_o == isolate_strap_i)) else $error("straps not loaded");
    speed_sel_a: assert property (
        aneg_enable_o [*3] ##0 $stable(aneg_speed_i)
        |-> speed_100_o == aneg_speed_i) else $error("manual speed used under negotiation");
    duplex_sel_a: assert property (
        aneg_enable_o [*3] ##0 $stable(aneg_duplex_i)
        |-> full_duplex_o == aneg_duplex_i) else $error("manual duplex used");
    srst_len_a: assert property (
        $fell(soft_reset_o) |-> hi_cnt_q == 5'h0F)
        else $error("software reset length wrong");
    srst_clear_a: assert property (
        $fell(soft_reset_o) |-> ##[0:3] (!loopback_o
        && isolate_o == isolate_strap_i)) else $error("bits not reset");
    pdown_exit_a: assert property (
        $fell(power_down_o) |=> !soft_reset_o [*4])
        else $error("first reset write reset the chip");
    restart_pulse_a: assert property (
        aneg_restart_o |=> !aneg_restart_o)
        else $error("restart not a pulse");
    ta_zero_a: assert property (
        $rose(mdio_oe_o) |-> !mdio_o)
        else $error("turnaround bit not zero");
endmodule // pbc_control_asserts
bind pbc_control pbc_control_asserts u_chk (.*);

// ===== dv/pbc_mac_model.sv
// Management station model: drives mdc and sees a pulled-up mdio line.
// Assumes the device drives mdio_o only while mdio_oe_o is high.
`timescale 1ns/1ps
module pbc_mac_model #(parameter logic [4:0] PHY = 5'h03) (
    input  logic mclk_i,
    input  logic mdio_o,
    input  logic mdio_oe_o,
    output logic mdc_o,
    output logic mdio_line_o
);
    logic drv_q = 1'b1;
    logic en_q = 1'b0;
    // The line idles high through its pull-up when nobody drives it.
    assign mdio_line_o = mdio_oe_o ? mdio_o : (en_q ? drv_q : 1'b1);
    initial mdc_o = 1'b0;
    // Sends one frame; bits change while mdc is low and are taken at its rise.
    task automatic xfer(input logic rd, input logic [4:0] ra, input logic [15:0] wd,
                        output logic [15:0] q);
        logic [39:0] f;
        f = {8'hFF, 2'b01, rd ? 2'b10 : 2'b01, PHY, ra, 2'b10, wd};
        q = 16'h0000;
        for (int i = 39; i >= -2; i--) begin
            @(posedge mclk_i);
            mdc_o <= 1'b0;
            en_q <= i >= 0 && !(rd && i < 18);
            drv_q <= i >= 0 ? f[i[5:0]] : 1'b1;
            repeat (8) @(posedge mclk_i);
            if (i >= 0 && i < 16) q = {q[14:0], mdio_line_o};
            mdc_o <= 1'b1;
            repeat (7) @(posedge mclk_i);
        end
        @(posedge mclk_i);
        mdc_o <= 1'b0;
    endtask
endmodule // pbc_mac_model

// ===== dv/phy_basic_control_upper_bits_test.sv
// Testbench for the basic control block with a modelled management station.
// Assumes the block answers at address 3 and mdc runs at a sixteenth of mclk.
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_mismatch++; $display("Error %0t: mismatch", $time); end end
module phy_basic_control_upper_bits_test;
    logic mclk_i = 1'b0, resetn_i = 1'b0, mdc_i, mdio_i;
    logic [4:0] phy_addr_i = 5'h03;
    logic autoneg_enable_strap_i = 1'b1, isolate_strap_i = 1'b1, speed_strap_i = 1'b1;
    logic speed_strap_present_i = 1'b0, duplex_strap_i = 1'b0;
    logic aneg_speed_i = 1'b0, aneg_duplex_i = 1'b1;
    logic mdio_o, mdio_oe_o, soft_reset_o, power_down_o, isolate_o, loopback_o;
    logic speed_100_o, full_duplex_o, aneg_enable_o, aneg_restart_o, col_test_o;
    logic [15:0] rd;
    int n_mismatch = 0;
    int checks = 0;
    int n_restart = 0;
    int n_srst = 0;
    pbc_control u_dut (.*);
    // Counts restart pulses and software reset cycles, which stand too briefly to poll.
    always @(posedge mclk_i) begin
        if (aneg_restart_o === 1'b1)
            n_restart <= n_restart + 1;
        if (soft_reset_o === 1'b1)
            n_srst <= n_srst + 1;
    end
    pbc_mac_model u_mac (.mclk_i, .mdio_o, .mdio_oe_o, .mdc_o(mdc_i), .mdio_line_o(mdio_i));
    // Runs the clock at 10 MHz.
    always #50 mclk_i = ~mclk_i;
    task automatic wr(input logic [4:0] ra, input logic [15:0] d);
        u_mac.xfer(1'b0, ra, d, rd);
        repeat (8) @(posedge mclk_i);
    endtask
    task automatic rdreg(input logic [4:0] ra);
        u_mac.xfer(1'b1, ra, 16'h0000, rd);
    endtask
    task automatic stop_test();
        if (n_mismatch == 0 && checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic t_defaults();
        rdreg(5'h00);
        `CHK(rd, 16'h1500)
        `CHK(aneg_enable_o, 1'b1)
    endtask
    task automatic t_manual();
        wr(5'h00, 16'h6380);
        `CHK(n_restart, 1)
        rdreg(5'h00);
        `CHK(rd, 16'h6180)
        `CHK({speed_100_o, loopback_o, isolate_o, full_duplex_o, col_test_o}, 5'h1B)
        wr(5'h00, 16'h3000);
        `CHK({speed_100_o, col_test_o}, 2'h0)
        aneg_speed_i <= 1'b1;
        repeat (3) @(posedge mclk_i);
        `CHK(speed_100_o, 1'b1)
    endtask
    task automatic t_other_regs();
        wr(5'h01, 16'h0000);
        wr(5'h10, 16'h0000);
        rdreg(5'h1F);
        `CHK(rd, 16'hFFFF)
        rdreg(5'h00);
        `CHK(rd, 16'h3000)
    endtask
    task automatic t_power_down();
        wr(5'h00, 16'h4800);
        `CHK(power_down_o, 1'b1)
        wr(5'h00, 16'h8000);
        `CHK({power_down_o, soft_reset_o, loopback_o}, 3'h1)
        `CHK(n_srst, 0)
        rdreg(5'h00);
        `CHK(rd, 16'h4000)
        isolate_strap_i <= 1'b0;
        speed_strap_present_i <= 1'b1;
        duplex_strap_i <= 1'b1;
        wr(5'h00, 16'h8000);
        `CHK(n_srst, 15)
        rdreg(5'h00);
        `CHK(rd, 16'h3000)
        `CHK({loopback_o, isolate_o}, 2'h0)
    endtask
    // Cuts a hang short well after the expected run length.
    initial begin
        repeat (20000) @(posedge mclk_i);
        n_mismatch++;
        stop_test();
    end
    // Resets the block, then runs the scenarios in order.
    initial begin
        repeat (20) @(posedge mclk_i);
        resetn_i <= 1'b1;
        repeat (8) @(posedge mclk_i);
        t_defaults();
        t_manual();
        t_other_regs();
        t_power_down();
        stop_test();
    end
endmodule // phy_basic_control_upper_bits_test
